// ===== pkg/pbw_pkg.sv
// constants, field layout and state types of the pushbutton wake/reset supervisor
package pbw_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int INT_PULSE_US = 128;
	localparam int INT_PULSE_CYCLES_DEF = (CLK_HZ / 1_000_000) * INT_PULSE_US;
	localparam logic [15:0] WD_TIMEOUT_MS = 16'h36b0;
	localparam logic [15:0] CYCLE_OFF_MS_DEF = 16'h0064;

	// duration tables in milliseconds, four 16-bit entries indexed by a 2-bit select
	localparam logic [63:0] FIRST_MS_TBL = 64'h03e8_01f4_0064_0032;
	localparam logic [63:0] SECOND_MS_TBL = 64'h1388_0bb8_07d0_03e8;
	localparam logic [63:0] LONG_MS_TBL = 64'h36b0_2710_1f40_0fa0;
	localparam logic [63:0] WARN_MS_TBL = 64'h07d0_03e8_01f4_0000;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [11:0] OFF_BUTTON_CTRL = 12'h000;
	localparam logic [11:0] OFF_DEV_CTRL = 12'h004;
	localparam logic [11:0] OFF_FLAGS = 12'h008;
	localparam logic [11:0] OFF_MASK = 12'h00c;
	localparam logic [11:0] OFF_STATUS = 12'h010;

	localparam int BC_FIRST_LSB = 0;
	localparam int BC_SECOND_LSB = 2;
	localparam int BC_WARN_LSB = 4;
	localparam int BC_LONG_LSB = 6;
	localparam logic [7:0] BUTTON_CTRL_RST = 8'h00;

	localparam int DC_ACTION_LSB = 0;
	localparam int DC_NEEDS_SUPPLY = 2;
	localparam int DC_WD_ENABLE = 3;
	localparam int DC_SOFT_CYCLE = 4;
	localparam int DC_LDO_ENABLE = 5;
	localparam logic [5:0] DEV_CTRL_RST = 6'h00;

	localparam logic [1:0] ACT_POWER_CYCLE = 2'h0;
	localparam int ACT_SHIP_BIT = 1;

	localparam int NFLAGS = 5;
	localparam int FLG_FIRST = 0;
	localparam int FLG_SECOND = 1;
	localparam int FLG_WARN = 2;
	localparam int FLG_INPUT = 3;
	localparam int FLG_EXT = 4;
	localparam logic [NFLAGS-1:0] MASK_RST = 5'h00;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {MODE_SHIP, MODE_WAKE, MODE_ACTIVE, MODE_CYCLE} pbw_mode_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pbw_apb_req_type;

	typedef struct packed {
		logic [15:0] first;
		logic [15:0] second;
		logic [15:0] warn;
		logic [15:0] long_ms;
		logic [1:0] action;
	} pbw_press_cfg_type;

	typedef struct packed {
		pbw_mode_type mode;
		logic [15:0] tick_cnt;
		logic [15:0] press_ms;
		pbw_press_cfg_type cfg;
		logic supply_held;
		logic armed;
		logic btn_low_prev;
		logic supply_prev;
		logic ext_prev;
		logic [NFLAGS-1:0] flags;
		logic [NFLAGS-1:0] mask;
		logic [7:0] btn_ctrl;
		logic [5:0] dev_ctrl;
		logic wd_run;
		logic [15:0] wd_ms;
		logic [15:0] off_ms;
		logic [15:0] pulse_cnt;
		logic int_low;
		logic rail;
		logic io_en;
		logic ldo;
		logic ship;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pbw_state_type;

	// picks one 16-bit millisecond entry from a duration table
	function automatic logic [15:0] pbw_dur_ms(input logic [1:0] sel, input logic [63:0] tbl);
		pbw_dur_ms = tbl[{sel, 4'h0} +: 16];
	endfunction

endpackage

// ===== hdl/pbw_supervisor.sv
// pushbutton wake, long-press reset, activity watchdog and interrupt pulse logic with an APB slave
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps

// How it works
// - without a good input supply, ship mode is left only after the button is held low the first interval
// - button falling in ship mode turns on the I/O supply and starts counting
// - button released early returns to ship mode with rail never powered
// - first interval reached while low powers the rail and optional regulator
// - a good input supply ends ship mode at once
// - after ship exit with button held, events wait for release and new press
// - first interval sets the first flag and sends one pulse
// - second interval sets the second flag and pulse, nothing else
// - flags stay until read; a pulse only when a flag becomes set
// - durations written during a press apply from the next press
// - long press expiry runs the selected action: power cycle, ship, or nothing
// - warning flag and pulse when the remaining time enters the margin
// - action may change during a press, but never into power cycle
// - with supply gating set, power cycle needs good supply the whole press
// - power cycle turns the rail off then on, I/O supply stays on
// - software command bit starts the same power cycle
// - enabled watchdog power-cycles if no bus activity within 14 s of supply
// - watchdog disabled after reset until its enable bit is written
// - interrupt pin is open drain, low for 128 us per event
// - no interrupts before valid start-up, none while the start-up fault input is high
// - masked events give no pulse, also not when later unmasked
// - flags trigger on rising status; input-good flag on both edges
module pbw_supervisor import pbw_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int INT_PULSE_CYCLES = INT_PULSE_CYCLES_DEF,
	parameter logic [15:0] CYCLE_OFF_MS = CYCLE_OFF_MS_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pushbutton_in_n,
	input wire logic input_supply_good,
	input wire logic startup_done,
	input wire logic startup_fault,
	input wire logic bus_activity,
	input wire logic ext_status,
	output logic int_o,
	output logic int_oe,
	output logic system_rail_en,
	output logic io_supply_en,
	output logic out_regulator_en,
	output logic ship_mode
);

	// ****************************************************************
	// state
	// ****************************************************************
	pbw_state_type s_reg;
	pbw_state_type s_next;
	pbw_apb_req_type req;
	logic int_zero_reg;

	logic btn_low;
	logic tick;
	logic [15:0] press_inc;
	logic acc_done;
	logic wr_done;
	logic rd_flags;
	logic int_ok;
	logic [NFLAGS-1:0] set_ev;
	logic [NFLAGS-1:0] new_flags;
	logic fire;
	pbw_press_cfg_type cfg_reg_view;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
	assign btn_low = ~pushbutton_in_n;
	assign tick = (s_reg.tick_cnt == 16'(TICK_CYCLES - 1));
	assign press_inc = s_reg.press_ms + 16'h0001;
	assign acc_done = req.psel & req.penable & s_reg.pready;
	assign wr_done = acc_done & req.pwrite & ~s_reg.pslverr;
	assign rd_flags = acc_done & ~req.pwrite & (req.paddr == OFF_FLAGS);
	assign int_ok = startup_done & ~startup_fault;

	// true on the tick at which the press count reaches the given duration
	function automatic logic press_hit(input logic [15:0] dur);
		press_hit = btn_low & tick & (press_inc == dur);
	endfunction

	assign cfg_reg_view = '{
		first: pbw_dur_ms(s_reg.btn_ctrl[BC_FIRST_LSB +: 2], FIRST_MS_TBL),
		second: pbw_dur_ms(s_reg.btn_ctrl[BC_SECOND_LSB +: 2], SECOND_MS_TBL),
		warn: pbw_dur_ms(s_reg.btn_ctrl[BC_WARN_LSB +: 2], WARN_MS_TBL),
		long_ms: pbw_dur_ms(s_reg.btn_ctrl[BC_LONG_LSB +: 2], LONG_MS_TBL),
		action: s_reg.dev_ctrl[DC_ACTION_LSB +: 2]
	};

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_next = s_reg;
		set_ev = '0;
		s_next.btn_low_prev = btn_low;
		s_next.supply_prev = input_supply_good;
		s_next.ext_prev = ext_status;
		s_next.tick_cnt = tick ? 16'h0000 : s_reg.tick_cnt + 16'h0001;

		// press timing; durations latch only while released
		if (!btn_low) begin
			s_next.press_ms = 16'h0000;
			s_next.cfg = cfg_reg_view;
			s_next.supply_held = input_supply_good;
			if (s_reg.mode == MODE_ACTIVE) begin
				s_next.armed = 1'b1;
			end
		end else begin
			if (tick && s_reg.press_ms != 16'hffff) begin
				s_next.press_ms = press_inc;
			end
			if (!input_supply_good) begin
				s_next.supply_held = 1'b0;
			end
			// action may be changed mid-press, except into power cycle
			if (cfg_reg_view.action != ACT_POWER_CYCLE || s_reg.cfg.action == ACT_POWER_CYCLE) begin
				s_next.cfg.action = cfg_reg_view.action;
			end
		end

		// watchdog armed by a supply connecting
		if (input_supply_good && !s_reg.supply_prev && s_reg.dev_ctrl[DC_WD_ENABLE]) begin
			s_next.wd_run = 1'b1;
			s_next.wd_ms = 16'h0000;
		end else if (bus_activity || !input_supply_good || !s_reg.dev_ctrl[DC_WD_ENABLE]) begin
			s_next.wd_run = 1'b0;
		end else if (s_reg.wd_run && tick) begin
			s_next.wd_ms = s_reg.wd_ms + 16'h0001;
		end

		case (s_reg.mode)
			MODE_SHIP: begin
				if (input_supply_good) begin
					s_next.mode = MODE_ACTIVE;
					s_next.armed = ~btn_low;
				end else if (btn_low && !s_reg.btn_low_prev) begin
					s_next.mode = MODE_WAKE;
				end
			end
			MODE_WAKE: begin
				if (input_supply_good) begin
					s_next.mode = MODE_ACTIVE;
					s_next.armed = ~btn_low;
				end else if (!btn_low) begin
					s_next.mode = MODE_SHIP;
				end else if (press_hit(s_reg.cfg.first)) begin
					s_next.mode = MODE_ACTIVE;
					s_next.armed = 1'b0;
				end
			end
			MODE_ACTIVE: begin
				if (s_reg.armed) begin
					set_ev[FLG_FIRST] = press_hit(s_reg.cfg.first);
					set_ev[FLG_SECOND] = press_hit(s_reg.cfg.second);
					set_ev[FLG_WARN] = (s_reg.cfg.warn != 16'h0000) &&
						press_hit(s_reg.cfg.long_ms - s_reg.cfg.warn);
					if (press_hit(s_reg.cfg.long_ms)) begin
						s_next.armed = 1'b0;
						if (s_reg.cfg.action[ACT_SHIP_BIT]) begin
							s_next.mode = MODE_SHIP;
						end else if (s_reg.cfg.action == ACT_POWER_CYCLE &&
							(!s_reg.dev_ctrl[DC_NEEDS_SUPPLY] || s_next.supply_held)) begin
							s_next.mode = MODE_CYCLE;
							s_next.off_ms = 16'h0000;
						end
					end
				end
				if (wr_done && req.paddr == OFF_DEV_CTRL && req.pwdata[DC_SOFT_CYCLE]) begin
					s_next.mode = MODE_CYCLE;
					s_next.off_ms = 16'h0000;
				end
				if (s_reg.wd_run && tick && s_next.wd_ms == WD_TIMEOUT_MS) begin
					s_next.mode = MODE_CYCLE;
					s_next.off_ms = 16'h0000;
					s_next.wd_run = 1'b0;
				end
			end
			MODE_CYCLE: begin
				if (tick) begin
					s_next.off_ms = s_reg.off_ms + 16'h0001;
				end
				if (s_reg.off_ms == CYCLE_OFF_MS) begin
					s_next.mode = MODE_ACTIVE;
				end
			end
			default: begin
				s_next.mode = MODE_ACTIVE;
			end
		endcase

		// supply outputs follow the mode
		s_next.rail = (s_next.mode == MODE_ACTIVE);
		s_next.io_en = (s_next.mode != MODE_SHIP);
		s_next.ldo = s_next.rail & s_reg.dev_ctrl[DC_LDO_ENABLE];
		s_next.ship = (s_next.mode == MODE_SHIP);

		// status edges
		set_ev[FLG_INPUT] = input_supply_good ^ s_reg.supply_prev;
		set_ev[FLG_EXT] = ext_status & ~s_reg.ext_prev;

		// flags: a read clears, a set in the same cycle wins
		new_flags = set_ev & ~s_reg.flags;
		s_next.flags = (rd_flags ? '0 : s_reg.flags) | set_ev;
		fire = int_ok && ((new_flags & ~s_reg.mask) != '0);

		// interrupt pulse, restarted by each new event
		if (fire) begin
			s_next.int_low = 1'b1;
			s_next.pulse_cnt = 16'(INT_PULSE_CYCLES - 1);
		end else if (s_reg.int_low) begin
			if (s_reg.pulse_cnt == 16'h0000) begin
				s_next.int_low = 1'b0;
			end else begin
				s_next.pulse_cnt = s_reg.pulse_cnt - 16'h0001;
			end
		end

		// ************************************************************
		// APB slave: one wait state, answer registered
		// ************************************************************
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		if (req.psel && req.penable && !s_reg.pready) begin
			s_next.pready = 1'b1;
			s_next.prdata = 32'h0000_0000;
			case (req.paddr)
				OFF_BUTTON_CTRL: s_next.prdata[7:0] = s_reg.btn_ctrl;
				OFF_DEV_CTRL: s_next.prdata[5:0] = s_reg.dev_ctrl;
				OFF_FLAGS: s_next.prdata[NFLAGS-1:0] = s_reg.flags;
				OFF_MASK: s_next.prdata[NFLAGS-1:0] = s_reg.mask;
				OFF_STATUS: s_next.prdata[7:0] = {s_reg.wd_run, s_reg.armed, input_supply_good,
					btn_low, s_reg.rail, s_reg.io_en, s_reg.mode};
				default: s_next.pslverr = 1'b1;
			endcase
		end
		if (wr_done) begin
			case (req.paddr)
				OFF_BUTTON_CTRL: s_next.btn_ctrl = req.pwdata[7:0];
				OFF_DEV_CTRL: begin
					s_next.dev_ctrl = req.pwdata[5:0];
					s_next.dev_ctrl[DC_SOFT_CYCLE] = 1'b0;
				end
				OFF_MASK: s_next.mask = req.pwdata[NFLAGS-1:0];
				default: s_next.mask = s_reg.mask;
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.mode <= MODE_ACTIVE;
			s_reg.btn_ctrl <= BUTTON_CTRL_RST;
			s_reg.dev_ctrl <= DEV_CTRL_RST;
			s_reg.mask <= MASK_RST;
			s_reg.supply_held <= 1'b1;
			s_reg.rail <= 1'b1;
			s_reg.io_en <= 1'b1;
			int_zero_reg <= 1'b0;
		end else begin
			s_reg <= s_next;
			int_zero_reg <= 1'b0;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign int_o = int_zero_reg;
	assign int_oe = s_reg.int_low;
	assign system_rail_en = s_reg.rail;
	assign io_supply_en = s_reg.io_en;
	assign out_regulator_en = s_reg.ldo;
	assign ship_mode = s_reg.ship;

	// ****************************************************************
	// assertions
	// ****************************************************************
	logic [15:0] low_len_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_len_reg <= 16'h0000;
		end else begin
			low_len_reg <= int_oe ? low_len_reg + 16'h0001 : 16'h0000;
		end
	end

	property p_pulse_width;
		@(posedge pclk) disable iff (!presetn)
		(int_oe && !fire && s_reg.pulse_cnt == 16'h0000) |=> !int_oe;
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("interrupt pulse did not end");

	property p_pulse_len;
		@(posedge pclk) disable iff (!presetn)
		$fell(int_oe) |-> ($past(low_len_reg) >= 16'(INT_PULSE_CYCLES - 1));
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("interrupt pulse too short");

	property p_wake_start;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.mode == MODE_SHIP && btn_low && !s_reg.btn_low_prev && !input_supply_good)
			|=> (io_supply_en && !system_rail_en && s_reg.mode == MODE_WAKE);
	endproperty
	a_wake_start: assert property (p_wake_start) else $error("wake did not start");

	property p_wake_abort;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.mode == MODE_WAKE && !btn_low && !input_supply_good) |=> (ship_mode && !system_rail_en);
	endproperty
	a_wake_abort: assert property (p_wake_abort) else $error("early release did not return to ship");

	property p_supply_exit;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.mode inside {MODE_SHIP, MODE_WAKE} && input_supply_good) |=> (system_rail_en && !ship_mode);
	endproperty
	a_supply_exit: assert property (p_supply_exit) else $error("supply did not end ship mode");

	property p_no_int_early;
		@(posedge pclk) disable iff (!presetn)
		(!int_ok && !int_oe) |=> !int_oe;
	endproperty
	a_no_int_early: assert property (p_no_int_early) else $error("interrupt before valid start-up");

	property p_cycle_io;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.mode == MODE_CYCLE) |-> (io_supply_en && !system_rail_en);
	endproperty
	a_cycle_io: assert property (p_cycle_io) else $error("power cycle state wrong");

	property p_soft_cycle;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.mode == MODE_ACTIVE && wr_done && req.paddr == OFF_DEV_CTRL && req.pwdata[DC_SOFT_CYCLE])
			|=> (!system_rail_en ##1 !system_rail_en);
	endproperty
	a_soft_cycle: assert property (p_soft_cycle) else $error("soft command did not cycle rail");

	property p_first_int;
		@(posedge pclk) disable iff (!presetn)
		(set_ev[FLG_FIRST] && !s_reg.flags[FLG_FIRST] && !s_reg.mask[FLG_FIRST] && int_ok)
			|=> (int_oe && s_reg.flags[FLG_FIRST]);
	endproperty
	a_first_int: assert property (p_first_int) else $error("first flag event gave no pulse");

	property p_masked_silent;
		@(posedge pclk) disable iff (!presetn)
		(!int_oe && ((set_ev & ~s_reg.flags & ~s_reg.mask) == '0)) |=> !int_oe;
	endproperty
	a_masked_silent: assert property (p_masked_silent) else $error("pulse without unmasked new flag");

	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		(s_reg.flags[FLG_SECOND] && !rd_flags) |=> s_reg.flags[FLG_SECOND];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without read");

	c_wake_exit: cover property (@(posedge pclk) disable iff (!presetn)
		s_reg.mode == MODE_WAKE ##1 s_reg.mode == MODE_ACTIVE);
	c_long_cycle: cover property (@(posedge pclk) disable iff (!presetn)
		s_reg.mode == MODE_ACTIVE && s_next.mode == MODE_CYCLE && btn_low);
	c_int_pulse: cover property (@(posedge pclk) disable iff (!presetn) $fell(int_oe));

endmodule

// ===== test/pbw_far_side.sv
// far-side model: pushbutton with pull-up and the host's view of the interrupt line
`timescale 1ns/1ps
module pbw_far_side (
	input wire logic pclk,
	input wire logic hold_low,
	input wire logic int_o,
	input wire logic int_oe,
	output logic pushbutton_in_n,
	output int pulse_count,
	output int last_width
);
	logic int_line;
	int low_cnt;

	// open-drain pin with a pull-up: a released pin reads high, never the last driven value
	assign int_line = int_oe ? int_o : 1'b1;

	initial begin
		pushbutton_in_n = 1'b1;
		pulse_count = 0;
		last_width = 0;
		low_cnt = 0;
	end

	// the button moves only just after an edge; the pull-up keeps it high when released
	always @(posedge pclk) begin
		pushbutton_in_n <= ~hold_low;
		if (int_line === 1'b0) begin
			low_cnt++;
		end else if (low_cnt > 0) begin
			// non-blocking so that the bench, woken by the same edge, reads a settled count
			pulse_count <= pulse_count + 1;
			last_width <= low_cnt;
			low_cnt = 0;
		end
	end
endmodule

// ===== test/pushbutton_wake_reset_irq_bench.sv
// self-checking bench for the pushbutton wake/reset supervisor
`timescale 1ns/1ps
module pushbutton_wake_reset_irq_bench;
	import pbw_pkg::*;
	// short tick and pulse so that a 4 s long press fits the run
	localparam int TK = 10;
	localparam int PW = 8;
	localparam logic [15:0] OFF_MS = 16'h0004;
	logic pclk, presetn, psel, penable, pwrite, hold_low, input_supply_good;
	logic startup_done, startup_fault, bus_activity, ext_status, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, int_o, int_oe, system_rail_en, io_supply_en, out_regulator_en, ship_mode, pushbutton_in_n;
	int pulse_count, last_width, num_errors, check_count, n;

	pbw_supervisor #(.TICK_CYCLES(TK), .INT_PULSE_CYCLES(PW), .CYCLE_OFF_MS(OFF_MS)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pushbutton_in_n(pushbutton_in_n), .input_supply_good(input_supply_good),
		.startup_done(startup_done), .startup_fault(startup_fault), .bus_activity(bus_activity),
		.ext_status(ext_status), .int_o(int_o), .int_oe(int_oe), .system_rail_en(system_rail_en),
		.io_supply_en(io_supply_en), .out_regulator_en(out_regulator_en), .ship_mode(ship_mode)
	);

	pbw_far_side far (
		.pclk(pclk), .hold_low(hold_low), .int_o(int_o), .int_oe(int_oe),
		.pushbutton_in_n(pushbutton_in_n), .pulse_count(pulse_count), .last_width(last_width)
	);

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic complete_run();
		if (num_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic press(input int cycles);
		@(posedge pclk);
		hold_low <= 1'b1;
		repeat (cycles) @(posedge pclk);
		hold_low <= 1'b0;
		repeat (30) @(posedge pclk);
	endtask

	task automatic wait_rail(input logic v, input int lim, output int k);
		k = 0;
		while (system_rail_en !== v && k < lim) begin
			@(posedge pclk);
			k++;
		end
		if (system_rail_en !== v) begin
			num_errors++;
			complete_run();
		end
	endtask

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, hold_low} = '0;
		{input_supply_good, startup_done, startup_fault, bus_activity, ext_status} = '0;
		num_errors = 0;
		check_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({ship_mode, system_rail_en, io_supply_en, out_regulator_en, int_oe}, 32'h0000000c);
		apb(1'b0, OFF_DEV_CTRL, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, OFF_BUTTON_CTRL, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, OFF_MASK, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, 12'h0f0, 32'hffffffff);
		check({31'h0, err}, 32'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		check(rd & 32'h000000bf, 32'h0000000e);
		// press before start-up completes: no pulse
		press(600);
		check(pulse_count, 32'h0);
		// start-up that ends in a fault stays silent as well
		startup_done <= 1'b1;
		startup_fault <= 1'b1;
		apb(1'b0, OFF_FLAGS, 32'h0);
		press(600);
		check(pulse_count, 32'h0);
		startup_fault <= 1'b0;
		apb(1'b0, OFF_FLAGS, 32'h0);
		check(rd, 32'h1);
		// short press past the first interval
		press(600);
		check(pulse_count, 32'h1);
		check(last_width, PW);
		check({31'h0, int_o}, 32'h0);
		apb(1'b0, OFF_FLAGS, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, OFF_FLAGS, 32'h0);
		check(rd, 32'h0);
		// masked press, then unmask while the flag stands
		apb(1'b1, OFF_MASK, 32'h1);
		press(600);
		apb(1'b1, OFF_MASK, 32'h0);
		repeat (20) @(posedge pclk);
		check(pulse_count, 32'h1);
		apb(1'b0, OFF_FLAGS, 32'h0);
		check(rd, 32'h1);
		// supply edges both ways, status rising edge
		// watchdog armed by the supply connecting, stopped by bus activity
		apb(1'b1, OFF_DEV_CTRL, 32'h8);
		input_supply_good <= 1'b1;
		repeat (20) @(posedge pclk);
		apb(1'b0, OFF_FLAGS, 32'h0);
		check(rd, 32'h8);
		apb(1'b0, OFF_STATUS, 32'h0);
		check(rd & 32'h00000080, 32'h00000080);
		bus_activity <= 1'b1;
		@(posedge pclk);
		bus_activity <= 1'b0;
		apb(1'b0, OFF_STATUS, 32'h0);
		check(rd & 32'h00000080, 32'h0);
		input_supply_good <= 1'b0;
		repeat (20) @(posedge pclk);
		apb(1'b0, OFF_FLAGS, 32'h0);
		check(rd, 32'h8);
		ext_status <= 1'b1;
		repeat (20) @(posedge pclk);
		apb(1'b0, OFF_FLAGS, 32'h0);
		check(rd, 32'h10);
		ext_status <= 1'b0;
		check(pulse_count, 32'h4);
		// software power cycle
		apb(1'b1, OFF_DEV_CTRL, 32'h10);
		wait_rail(1'b0, 20, n);
		check({31'h0, io_supply_en}, 32'h1);
		wait_rail(1'b1, (OFF_MS + 3) * TK, n);
		check({31'h0, n >= (OFF_MS - 1) * TK}, 32'h1);
		// long press with ship action; a late change into power cycle is refused
		apb(1'b1, OFF_BUTTON_CTRL, 32'h10);
		apb(1'b1, OFF_DEV_CTRL, 32'h22);
		@(posedge pclk);
		hold_low <= 1'b1;
		repeat (1000) @(posedge pclk);
		apb(1'b1, OFF_DEV_CTRL, 32'h20);
		repeat (40000) @(posedge pclk);
		check({ship_mode, system_rail_en}, 32'h2);
		hold_low <= 1'b0;
		repeat (30) @(posedge pclk);
		apb(1'b0, OFF_FLAGS, 32'h0);
		check(rd, 32'h7);
		check(pulse_count, 32'h7);
		// ship: early release returns to ship, full press wakes
		@(posedge pclk);
		hold_low <= 1'b1;
		repeat (100) @(posedge pclk);
		check({io_supply_en, system_rail_en}, 32'h2);
		hold_low <= 1'b0;
		repeat (20) @(posedge pclk);
		check({ship_mode, io_supply_en, system_rail_en}, 32'h4);
		press(600);
		check({ship_mode, system_rail_en, out_regulator_en}, 32'h3);
		complete_run();
	end
endmodule
